/* File: src/ddr2_cmd_consts.vh */
`ifndef DDR2_CMD_CONSTS_VH
`define DDR2_CMD_CONSTS_VH

// Pin widths
`define ADDR_W        15
`define BANK_W        3
`define NUM_BANKS     8
`define NUM_RANKS     2
`define ROW_W         15
`define MR_SEL_W      2

// Auto precharge / all-bank address bit
`define AP_BIT        10

// Field positions
`define CL_LSB        4
`define CL_MSB        6
`define COL_LO_MSB    9
`define COL_SPLIT     11
`define RANKS_NONE    2'h0

// Command codes {ras_n, cas_n, we_n}
`define CMD_LMR       3'h0
`define CMD_REF       3'h1
`define CMD_PRE       3'h2
`define CMD_ACT       3'h3
`define CMD_WR        3'h4
`define CMD_RD        3'h5
`define CMD_NOP       3'h7

// Row / column fill values
`define ROW_ZERO      15'h0000
`define COL_ZERO      12'h000
`define OP_ZERO       15'h0000
`define BANKS_IDLE    8'h00
`define BANK_ZERO     3'h0
`define MR_ZERO       2'h0

// Read latency codes and burst length
`define CL_W          3
`define CL_DEF        3'h4
`define BURST_CYC     4'h2
`define CNT_ZERO      4'h0

// Power state encodings
`define PWR_ACTIVE    2'h0
`define PWR_PRE_PD    2'h1
`define PWR_ACT_PD    2'h2
`define PWR_SELF_REF  2'h3

`endif

/* File: src/ddr2_dual_rank_cmd_addr_interface.v */
// Overview of operation
// RL1: ACTIVATE takes full row address and opens that row in the bank.
// RL2: READ/WRITE take column address; bit ten requests auto precharge.
// RL3: PRECHARGE bit ten low closes one bank, high closes all.
// RL4: LOAD MODE address pins carry opcode for selected mode register.
// RL5: Bank address pins pick one of eight banks for bank commands.
// RL6: LOAD MODE bank address picks base or extended registers one-three.
// RL7: All address and control inputs sampled on rising clock crossing.
// RL8: Read data timing referenced to the input clock, not internal clock.
// RL9: By-four: fifteen row bits, column bits eleven and nine to zero.
// RL10: By-eight: fifteen row bits, column bits nine to zero.
// RL11: Each of two ranks tracks eight banks with independent open rows.
// RL12: Controller drives separate select, enable, termination per rank.
// RL13: Controller programs read latency six, five or four per period.
// RL14: Chip select high masks commands; low enables that rank's decoder.
// RL15: Command decoded from select with row, column and write strobes.
// RL16: Clock enable low enters precharge, active power-down or self refresh.
// RL17: Write data with mask high is not stored.
// RL18: Controller never selects both ranks for a read together.
// RL19: Controller holds dependent commands until timing counts expire.
`timescale 1ns/1ps
`default_nettype none
`include "ddr2_cmd_consts.vh"

module ddr2_dual_rank_cmd_addr_interface (
  // Clock and reset
  input  wire                   clock_i,
  input  wire                   rst_i,
  // Organisation: high selects by-eight
  input  wire                   org_x8_i,
  // Per-rank controls
  input  wire [`NUM_RANKS-1:0]  cs_n_i,
  input  wire [`NUM_RANKS-1:0]  cke_i,
  input  wire [`NUM_RANKS-1:0]  odt_i,
  // Shared command and address
  input  wire                   ras_n_i,
  input  wire                   cas_n_i,
  input  wire                   we_n_i,
  input  wire [`BANK_W-1:0]     bank_i,
  input  wire [`ADDR_W-1:0]     addr_i,
  // Write data mask
  input  wire                   wr_data_valid_i,
  input  wire                   dm_i,
  // Decoded access
  output reg                    rd_o,
  output reg                    wr_o,
  output reg                    auto_pre_o,
  output reg                    wr_store_o,
  output reg  [`NUM_RANKS-1:0]  rank_o,
  output reg  [`BANK_W-1:0]     bank_o,
  output reg  [`ROW_W-1:0]      row_o,
  output reg  [11:0]            col_o,
  // Mode register load
  output reg                    mr_load_o,
  output reg  [`MR_SEL_W-1:0]   mr_sel_o,
  output reg  [`ADDR_W-1:0]     mr_op_o,
  output reg  [`CL_W-1:0]       cas_lat_o,
  // Status
  output wire [`NUM_BANKS-1:0]  open0_o,
  output wire [`NUM_BANKS-1:0]  open1_o,
  output wire [1:0]             pwr0_o,
  output wire [1:0]             pwr1_o,
  output reg  [`NUM_RANKS-1:0]  odt_on_o,
  output reg                    rd_clash_o
);

  // RL15: command decode
  function [2:0] cmd_of;
    input ras;
    input cas;
    input we;
    begin
      cmd_of = {ras, cas, we};
    end
  endfunction

  // Command strobe for one decoder
  function is_cmd;
    input       en;
    input [2:0] code;
    input [2:0] want;
    begin
      is_cmd = en && (code == want);
    end
  endfunction

  wire [2:0] cmd = cmd_of(ras_n_i, cas_n_i, we_n_i);
  // RL14: select enables decoder
  wire [`NUM_RANKS-1:0] sel = ~cs_n_i & cke_i;
  wire [`NUM_RANKS-1:0] act_r, rd_r, wr_r, pre_r, ref_r;
  wire [`ROW_W*`NUM_BANKS-1:0] rows0, rows1;
  wire [`NUM_BANKS-1:0] open_r [0:`NUM_RANKS-1];
  wire [1:0]            pwr_r  [0:`NUM_RANKS-1];
  wire [`ROW_W*`NUM_BANKS-1:0] rows_r [0:`NUM_RANKS-1];

  // RL9: by-four column skips bit ten
  // RL10: by-eight column bits nine to zero
  reg  [11:0] col_map;
  always @* begin
    col_map = `COL_ZERO;
    if (org_x8_i) begin
      col_map[`COL_LO_MSB:0] = addr_i[`COL_LO_MSB:0];
    end else begin
      col_map[`COL_LO_MSB:0] = addr_i[`COL_LO_MSB:0];
      col_map[`COL_LO_MSB+1] = addr_i[`COL_SPLIT];
    end
  end

  // RL11: one bank tracker per rank
  genvar r;
  generate
    for (r = 0; r < `NUM_RANKS; r = r + 1) begin : g_rank
      assign act_r[r] = is_cmd(sel[r], cmd, `CMD_ACT);
      assign rd_r[r]  = is_cmd(sel[r], cmd, `CMD_RD);
      assign wr_r[r]  = is_cmd(sel[r], cmd, `CMD_WR);
      assign pre_r[r] = is_cmd(sel[r], cmd, `CMD_PRE);
      assign ref_r[r] = is_cmd(~cs_n_i[r], cmd, `CMD_REF);
      ddr2_rank u_rank (
        .clock_i (clock_i),
        .rst_i   (rst_i),
        .act_i   (act_r[r]),
        .rd_i    (rd_r[r]),
        .wr_i    (wr_r[r]),
        .pre_i   (pre_r[r]),
        .ref_i   (ref_r[r]),
        .cke_i   (cke_i[r]),
        .bank_i  (bank_i),
        .addr_i  (addr_i),
        .open_o  (open_r[r]),
        .rows_o  (rows_r[r]),
        .pwr_o   (pwr_r[r])
      );
    end
  endgenerate

  assign open0_o = open_r[0];
  assign open1_o = open_r[1];
  assign pwr0_o  = pwr_r[0];
  assign pwr1_o  = pwr_r[1];
  assign rows0   = rows_r[0];
  assign rows1   = rows_r[1];

  wire       any_rd = |rd_r;
  wire       any_wr = |wr_r;
  wire       lmr_any = is_cmd(|sel, cmd, `CMD_LMR);
  // RL5: bank selects open row
  reg  [`ROW_W-1:0] row_sel;
  always @* begin
    row_sel = rows0[bank_i*`ROW_W +: `ROW_W];
    if (rd_r[1] || wr_r[1]) begin
      row_sel = rows1[bank_i*`ROW_W +: `ROW_W];
    end
  end

  // RL7: everything registered on rising edge
  // RL8: outputs from input clock
  always @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      rd_o       <= 1'b0;
      wr_o       <= 1'b0;
      auto_pre_o <= 1'b0;
    end else begin
      rd_o       <= any_rd;
      wr_o       <= any_wr;
      // RL2: auto precharge flag
      auto_pre_o <= (any_rd | any_wr) & addr_i[`AP_BIT];
    end
  end

  // Access fields held until next access
  always @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      rank_o <= `RANKS_NONE;
      bank_o <= `BANK_ZERO;
      row_o  <= `ROW_ZERO;
      col_o  <= `COL_ZERO;
    end else if (any_rd | any_wr) begin
      rank_o <= rd_r | wr_r;
      bank_o <= bank_i;
      row_o  <= row_sel;
      col_o  <= col_map;
    end
  end

  // Write mask and rank status
  always @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      wr_store_o <= 1'b0;
      odt_on_o   <= `RANKS_NONE;
      rd_clash_o <= 1'b0;
    end else begin
      // RL17: masked data not stored
      wr_store_o <= wr_data_valid_i & ~dm_i;
      // RL18: flag double-rank read
      rd_clash_o <= &rd_r;
      odt_on_o   <= odt_i & cke_i;
    end
  end

  // RL4: opcode into selected register
  // RL6: bank address picks register
  always @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      mr_load_o <= 1'b0;
      mr_sel_o  <= `MR_ZERO;
      mr_op_o   <= `OP_ZERO;
    end else begin
      mr_load_o <= lmr_any;
      if (lmr_any) begin
        mr_sel_o <= bank_i[`MR_SEL_W-1:0];
        mr_op_o  <= addr_i;
      end
    end
  end

  // RL13: read latency field
  always @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      cas_lat_o <= `CL_DEF;
    end else if (lmr_any && (bank_i == `BANK_ZERO)) begin
      cas_lat_o <= addr_i[`CL_MSB:`CL_LSB];
    end
  end

endmodule
`default_nettype wire

/* File: src/ddr2_rank.v */
`timescale 1ns/1ps
`default_nettype none
`include "ddr2_cmd_consts.vh"

module ddr2_rank (
  // Clock and reset
  input  wire                   clock_i,
  input  wire                   rst_i,
  // Decoded command strobes
  input  wire                   act_i,
  input  wire                   rd_i,
  input  wire                   wr_i,
  input  wire                   pre_i,
  input  wire                   ref_i,
  input  wire                   cke_i,
  input  wire [`BANK_W-1:0]     bank_i,
  input  wire [`ADDR_W-1:0]     addr_i,
  // Bank state
  output wire [`NUM_BANKS-1:0]  open_o,
  output wire [`ROW_W*`NUM_BANKS-1:0] rows_o,
  output reg  [1:0]             pwr_o
);

  reg  [`NUM_BANKS-1:0] open_ff;
  reg  [`ROW_W-1:0]     row_ff [0:`NUM_BANKS-1];
  reg                   cke_ff;
  wire [`NUM_BANKS-1:0] bank_dec = {{(`NUM_BANKS-1){1'b0}}, 1'b1} << bank_i;

  genvar g;
  generate
    for (g = 0; g < `NUM_BANKS; g = g + 1) begin : g_bank
      wire hit = bank_dec[g];
      assign rows_o[g*`ROW_W +: `ROW_W] = row_ff[g];
      always @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
          open_ff[g] <= 1'b0;
          row_ff[g]  <= `ROW_ZERO;
        // RL1: open addressed row
        end else if (act_i && hit) begin
          open_ff[g] <= 1'b1;
          row_ff[g]  <= addr_i;
        // RL3: single or all banks
        end else if (pre_i && (hit || addr_i[`AP_BIT])) begin
          open_ff[g] <= 1'b0;
        // RL2: auto precharge closes bank in the access cycle
        end else if ((rd_i || wr_i) && hit && addr_i[`AP_BIT]) begin
          open_ff[g] <= 1'b0;
        end
      end
    end
  endgenerate

  assign open_o = open_ff;

  // RL16: power state on clock enable
  always @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      cke_ff <= 1'b1;
      pwr_o  <= `PWR_ACTIVE;
    end else begin
      cke_ff <= cke_i;
      if (cke_i)
        pwr_o <= `PWR_ACTIVE;
      else if (cke_ff) begin
        if (open_ff != `BANKS_IDLE)
          pwr_o <= `PWR_ACT_PD;
        else if (ref_i)
          pwr_o <= `PWR_SELF_REF;
        else
          pwr_o <= `PWR_PRE_PD;
      end
    end
  end

endmodule
`default_nettype wire

/* File: testbench/ddr2_cmd_sva.sv */
`timescale 1ns/1ps
`default_nettype none
`include "ddr2_cmd_consts.vh"
module ddr2_cmd_sva (
  // Clock and reset
  input wire logic        clock_i,
  input wire logic        rst_i,
  // Command pins
  input wire logic [1:0]  cs_n_i,
  input wire logic [1:0]  cke_i,
  input wire logic        ras_n_i,
  input wire logic        cas_n_i,
  input wire logic        we_n_i,
  input wire logic [2:0]  bank_i,
  input wire logic [14:0] addr_i,
  input wire logic        wr_data_valid_i,
  input wire logic        dm_i,
  // Decoded outputs
  input wire logic        rd_o,
  input wire logic        wr_o,
  input wire logic        auto_pre_o,
  input wire logic        wr_store_o,
  input wire logic        mr_load_o,
  input wire logic [1:0]  mr_sel_o
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (rst_i);
  wire logic [2:0] cmd  = {ras_n_i, cas_n_i, we_n_i};
  wire logic       take = |(~cs_n_i & cke_i);
  rd_go_a: assert property (take && cmd == `CMD_RD |=> rd_o)
    else $error("read not decoded");
  rd_cause_a: assert property (rd_o |-> $past(take && cmd == `CMD_RD))
    else $error("read pulse without command");
  wr_go_a: assert property (take && cmd == `CMD_WR |=> wr_o)
    else $error("write not decoded");
  ap_flag_a: assert property (take && (cmd == `CMD_RD || cmd == `CMD_WR)
    |=> auto_pre_o == $past(addr_i[10])) else $error("auto precharge wrong");
  mr_sel_a: assert property (take && cmd == `CMD_LMR
    |=> mr_load_o && mr_sel_o == $past(bank_i[1:0])) else $error("mode sel");
  masked_a: assert property (&cs_n_i |=> !rd_o && !wr_o && !mr_load_o)
    else $error("deselected command acted");
  cke_off_a: assert property (cke_i == 2'h0 |=> !rd_o && !wr_o)
    else $error("access while clock disabled");
  store_on_a: assert property (wr_data_valid_i && !dm_i |=> wr_store_o)
    else $error("unmasked data dropped");
  store_off_a: assert property (dm_i |=> !wr_store_o)
    else $error("masked data stored");
  cover property (take && cmd == `CMD_RD && addr_i[10]);
  cover property (take && cmd == `CMD_LMR);
  cover property (wr_data_valid_i && dm_i);
endmodule
bind ddr2_dual_rank_cmd_addr_interface ddr2_cmd_sva chk (
  .clock_i(clock_i), .rst_i(rst_i), .cs_n_i(cs_n_i), .cke_i(cke_i),
  .ras_n_i(ras_n_i), .cas_n_i(cas_n_i), .we_n_i(we_n_i), .bank_i(bank_i),
  .addr_i(addr_i), .wr_data_valid_i(wr_data_valid_i), .dm_i(dm_i),
  .rd_o(rd_o), .wr_o(wr_o), .auto_pre_o(auto_pre_o), .wr_store_o(wr_store_o),
  .mr_load_o(mr_load_o), .mr_sel_o(mr_sel_o));
`default_nettype wire

/* File: testbench/ddr2_ctrl_model.sv */
`timescale 1ns/1ps
`default_nettype none
`include "ddr2_cmd_consts.vh"
module ddr2_ctrl_model (
  // Clock
  input  wire logic        clock_i,
  // Command and address pins
  output var  logic [1:0]  cs_n_o,
  output var  logic [1:0]  cke_o,
  output var  logic [1:0]  odt_o,
  output var  logic [2:0]  cmd_o,
  output var  logic [2:0]  bank_o,
  output var  logic [14:0] addr_o
);
  initial begin
    cs_n_o = 2'h3;
    cke_o = 2'h3;
    odt_o = 2'h0;
    cmd_o = `CMD_NOP;
    bank_o = 3'h0;
    addr_o = 15'h0000;
  end
  task pins(input logic [1:0] cke, input logic [1:0] odt);
    @(negedge clock_i);
    cke_o = cke;
    odt_o = odt;
  endtask
  // one idle cycle after each command
  task send(input logic [1:0] cs_n, input logic [2:0] cmd,
            input logic [2:0] ba, input logic [14:0] a);
    @(negedge clock_i);
    cs_n_o = cs_n;
    cmd_o = cmd;
    bank_o = ba;
    addr_o = a;
    @(negedge clock_i);
    cs_n_o = 2'h3;
    cmd_o = `CMD_NOP;
    bank_o = ~ba;
    addr_o = ~a;
  endtask
endmodule
`default_nettype wire

/* File: testbench/test_ddr2_dual_rank_cmd_addr_interface.sv */
`timescale 1ns/1ps
`default_nettype none
`include "ddr2_cmd_consts.vh"
module test_ddr2_dual_rank_cmd_addr_interface;
  logic        clock_i, rst_i, org, dv, dm;
  int          errors, n_tests, i;
  wire logic [1:0]  cs_n, cke, odt, rk, ms, p0, p1, oo;
  wire logic [2:0]  cmd, ba, cl, bo;
  wire logic [14:0] a, row, op;
  wire logic [11:0] col;
  wire logic [7:0]  o0, o1;
  wire logic        rd, wr, ap, ws, ml, rc;
  ddr2_ctrl_model ctrl (.clock_i(clock_i), .cs_n_o(cs_n), .cke_o(cke),
    .odt_o(odt), .cmd_o(cmd), .bank_o(ba), .addr_o(a));
  ddr2_dual_rank_cmd_addr_interface DUT (.clock_i(clock_i), .rst_i(rst_i),
    .org_x8_i(org), .cs_n_i(cs_n), .cke_i(cke), .odt_i(odt),
    .ras_n_i(cmd[2]), .cas_n_i(cmd[1]), .we_n_i(cmd[0]), .bank_i(ba),
    .addr_i(a), .wr_data_valid_i(dv), .dm_i(dm), .rd_o(rd), .wr_o(wr),
    .auto_pre_o(ap), .wr_store_o(ws), .rank_o(rk), .bank_o(bo), .row_o(row),
    .col_o(col), .mr_load_o(ml), .mr_sel_o(ms), .mr_op_o(op),
    .cas_lat_o(cl), .open0_o(o0), .open1_o(o1), .pwr0_o(p0), .pwr1_o(p1),
    .odt_on_o(oo), .rd_clash_o(rc));
  task chk(input logic [14:0] got, input logic [14:0] exp);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task report_and_stop;
    if (errors == 0 && n_tests > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  initial begin
    clock_i = 0;
    forever #2.5 clock_i = ~clock_i;
  end
  initial begin
    #100000;
    errors++;
    report_and_stop;
  end
  initial begin
    {rst_i, org, dv, dm} = 4'h8;
    repeat (12) @(negedge clock_i);
    rst_i = 0;
    ctrl.send(2'h2, `CMD_ACT, 3'h3, 15'h5a5a);
    chk(o0, 8'h08);
    chk(cl, 3'h4);
    ctrl.send(2'h2, `CMD_RD, 3'h3, 15'h0c05);
    chk(rd, 1'b1);
    chk(ap, 1'b1);
    chk(row, 15'h5a5a);
    chk(col, 12'h405);
    chk(o0, 8'h00);
    chk(rk, 2'h1);
    chk(bo, 3'h3);
    chk(rc, 1'b0);
    org = 1;
    ctrl.send(2'h1, `CMD_ACT, 3'h2, 15'h1234);
    ctrl.send(2'h1, `CMD_WR, 3'h2, 15'h0bff);
    chk(wr, 1'b1);
    chk(ap, 1'b0);
    chk(col, 12'h3ff);
    chk(rk, 2'h2);
    chk(o1, 8'h04);
    ctrl.send(2'h1, `CMD_ACT, 3'h5, 15'h0007);
    ctrl.send(2'h2, `CMD_ACT, 3'h5, 15'h0009);
    ctrl.send(2'h1, `CMD_PRE, 3'h5, 15'h0000);
    chk(o1, 8'h04);
    ctrl.send(2'h1, `CMD_PRE, 3'h0, 15'h0400);
    chk(o1, 8'h00);
    chk(o0, 8'h20);
    for (i = 0; i < 4; i++) begin
      ctrl.send(2'h2, `CMD_LMR, i[2:0], 15'h0050 + i[14:0]);
      chk(ms, i[1:0]);
      chk(ml, 1'b1);
      chk(op, 15'h0050 + i[14:0]);
    end
    chk(cl, 3'h5);
    ctrl.send(2'h3, `CMD_RD, 3'h5, 15'h0000);
    chk(rd, 1'b0);
    ctrl.pins(2'h2, 2'h3);
    ctrl.send(2'h2, `CMD_RD, 3'h5, 15'h0000);
    chk(rd, 1'b0);
    chk(p0, 2'h2);
    chk(oo, 2'h2);
    ctrl.pins(2'h3, 2'h0);
    ctrl.send(2'h0, `CMD_RD, 3'h5, 15'h0000);
    chk(rc, 1'b1);
    chk(p0, 2'h0);
    fork
      ctrl.pins(2'h1, 2'h0);
      ctrl.send(2'h1, `CMD_REF, 3'h0, 15'h0000);
    join
    chk(p1, 2'h3);
    chk(oo, 2'h0);
    dv = 1;
    @(negedge clock_i);
    chk(ws, 1'b1);
    dm = 1;
    @(negedge clock_i);
    chk(ws, 1'b0);
    report_and_stop;
  end
endmodule
`default_nettype wire
